// [src/swsc_pkg.sv]
// shared constants, types and helpers of the single-wire slave command layer
package swsc_pkg;

   // timing
   localparam int CLK_MHZ = 50;
   localparam int RESET_LOW_US = 120;
   localparam int RESET_LOW_CYC = RESET_LOW_US * CLK_MHZ;
   localparam int SAMPLE_US = 30;
   localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
   localparam int READ_HOLD_US = 30;
   localparam int READ_HOLD_CYC = READ_HOLD_US * CLK_MHZ;
   localparam int PRES_WAIT_US = 30;
   localparam int PRES_WAIT_CYC = PRES_WAIT_US * CLK_MHZ;
   localparam int PRES_LOW_US = 60;
   localparam int PRES_LOW_CYC = PRES_LOW_US * CLK_MHZ;
   localparam int COPY_TIME_US = 2000;
   localparam int COPY_CYC = COPY_TIME_US * CLK_MHZ;

   typedef logic [19:0] swsc_cnt_t;

   // net address commands
   localparam logic [7:0] OP_READ_NET_A = 8'h33;
   localparam logic [7:0] OP_READ_NET_B = 8'h39;
   localparam logic [7:0] OP_MATCH_NET = 8'h55;
   localparam logic [7:0] OP_SKIP_NET = 8'hcc;
   localparam logic [7:0] OP_SEARCH_NET = 8'hf0;
   // function commands
   localparam logic [7:0] OP_READ_DATA = 8'h69;
   localparam logic [7:0] OP_WRITE_DATA = 8'h6c;
   localparam logic [7:0] OP_COPY_DATA = 8'h48;
   localparam logic [7:0] OP_RECALL_DATA = 8'hb8;
   localparam logic [7:0] OP_LOCK_BLOCK = 8'h6a;

   // net address layout and counters
   localparam logic [5:0] NET_LAST_BIT = 6'h3f;
   localparam logic [5:0] BYTE_LAST_BIT = 6'h07;
   localparam int CRC_DATA_BITS = 56;
   localparam logic [7:0] CRC_POLY = 8'h8c;

   // memory map
   localparam logic [7:0] ADDR_LAST = 8'hff;
   localparam logic [7:0] EE_FIRST = 8'h20;
   localparam logic [7:0] EE_LAST = 8'h7f;
   localparam int BLOCK_SHIFT = 5;
   localparam logic [1:0] SUSP_THR_OFF = 2'h0;

   typedef enum logic [3:0] {
      CS_IDLE = 4'b0000,
      CS_NET_CMD = 4'b0001,
      CS_NET_READ = 4'b0010,
      CS_NET_MATCH = 4'b0011,
      CS_SEARCH = 4'b0100,
      CS_FUNC_CMD = 4'b0101,
      CS_ADDR = 4'b0110,
      CS_READ = 4'b0111,
      CS_WRITE = 4'b1000,
      CS_IGNORE = 4'b1001
   } swsc_cmd_state_t;

   typedef enum logic [2:0] {
      SS_IDLE = 3'b000,
      SS_SLOT = 3'b001,
      SS_RESET = 3'b010,
      SS_PWAIT = 3'b011,
      SS_PRES = 3'b100
   } swsc_slot_state_t;

   // crc over the low 56 address bits, lsb first
   function automatic logic [7:0] swsc_crc8(input logic [55:0] d);
      logic [7:0] c;
      logic fb;
      c = 8'h00;
      for (int i = 0; i < CRC_DATA_BITS; i++) begin
         fb = c[0] ^ d[i];
         c = c >> 1;
         if (fb) begin
            c = c ^ CRC_POLY;
         end
      end
      return c;
   endfunction

endpackage

// [src/swsc_slot_engine.sv]
// bus line slot engine: reset detection, presence pulse, bit slots
`timescale 1ns/1ps
module swsc_slot_engine import swsc_pkg::*; #(
   parameter int RESET_CYC = RESET_LOW_CYC
) (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic dq_in,
   input wire logic tx_en_in,
   input wire logic tx_bit_in,
   output logic dq_oe_out,
   output logic slot_done_out,
   output logic slot_bit_out,
   output logic reset_seen_out,
   output logic low_long_out
);

   typedef struct packed {
      swsc_slot_state_t state;
      swsc_cnt_t cnt;
      swsc_cnt_t low_cnt;
      logic dq_prev;
      logic oe;
      logic done;
      logic bitv;
      logic rst_pulse;
      logic low_long;
   } swsc_slot_regs_t;

   swsc_slot_regs_t q_ff;
   swsc_slot_regs_t nxt_q;

   always_comb begin
      nxt_q = q_ff;
      nxt_q.done = 1'b0;
      nxt_q.rst_pulse = 1'b0;
      nxt_q.dq_prev = dq_in;
      // own presence drive must not count toward a reset
      if (!dq_in && q_ff.state != SS_PRES) begin
         if (q_ff.low_cnt <= swsc_cnt_t'(RESET_CYC)) begin
            nxt_q.low_cnt = q_ff.low_cnt + 20'h00001;
         end
      end else begin
         nxt_q.low_cnt = '0;
      end
      nxt_q.low_long = q_ff.low_cnt > swsc_cnt_t'(RESET_CYC);
      case (q_ff.state)
         SS_IDLE: begin
            if (q_ff.dq_prev && !dq_in) begin
               nxt_q.state = SS_SLOT;
               nxt_q.cnt = '0;
               nxt_q.oe = tx_en_in && !tx_bit_in;
            end
         end
         SS_SLOT: begin
            nxt_q.cnt = q_ff.cnt + 20'h00001;
            if (q_ff.cnt == swsc_cnt_t'(READ_HOLD_CYC)) begin
               nxt_q.oe = 1'b0;
            end
            if (q_ff.cnt == swsc_cnt_t'(SAMPLE_CYC)) begin
               nxt_q.done = 1'b1;
               nxt_q.bitv = dq_in;
            end
            if (q_ff.cnt > swsc_cnt_t'(SAMPLE_CYC) && dq_in) begin
               nxt_q.state = SS_IDLE;
            end
         end
         SS_RESET: begin
            if (dq_in) begin
               nxt_q.state = SS_PWAIT;
               nxt_q.cnt = '0;
            end
         end
         SS_PWAIT: begin
            nxt_q.cnt = q_ff.cnt + 20'h00001;
            if (q_ff.cnt == swsc_cnt_t'(PRES_WAIT_CYC - 1)) begin
               nxt_q.state = SS_PRES;
               nxt_q.cnt = '0;
               nxt_q.oe = 1'b1;
            end
         end
         SS_PRES: begin
            nxt_q.cnt = q_ff.cnt + 20'h00001;
            if (q_ff.cnt == swsc_cnt_t'(PRES_LOW_CYC - 1)) begin
               nxt_q.state = SS_IDLE;
               nxt_q.oe = 1'b0;
            end
         end
         default: begin
            nxt_q.state = SS_IDLE;
            nxt_q.oe = 1'b0;
         end
      endcase
      // a low longer than the reset time wins over any slot
      if (q_ff.state != SS_RESET && q_ff.state != SS_PRES && !dq_in
          && q_ff.low_cnt == swsc_cnt_t'(RESET_CYC)) begin
         nxt_q.state = SS_RESET;
         nxt_q.rst_pulse = 1'b1;
         nxt_q.oe = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         q_ff <= '{state: SS_IDLE, dq_prev: 1'b1, default: '0};
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign dq_oe_out = q_ff.oe;
   assign slot_done_out = q_ff.done;
   assign slot_bit_out = q_ff.bitv;
   assign reset_seen_out = q_ff.rst_pulse;
   assign low_long_out = q_ff.low_long;

endmodule

// [src/swsc_command_layer.sv]
// single-wire slave transaction layer: net address and memory function commands
`timescale 1ns/1ps
module swsc_command_layer import swsc_pkg::*; #(
   parameter int RESET_CYC = RESET_LOW_CYC,
   parameter int COPY_CYCLES = COPY_CYC,
   parameter logic [7:0] FAMILY_CODE = 8'h5a, // arbitrary value
   parameter logic [47:0] SERIAL_NUMBER = 48'h0000_0000_0001 // arbitrary value
) (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic dq_in,
   output logic dq_out,
   output logic dq_oe_out,
   input wire logic net_address_opcode_select_in,
   input wire logic power_saving_enable_in,
   input wire logic [1:0] suspend_threshold_select_in,
   input wire logic current_in_suspend_window_in,
   output logic suspend_out,
   output logic [7:0] mem_addr_out,
   input wire logic [7:0] mem_rd_data_in,
   input wire logic addr_writable_in,
   output logic mem_wr_en_out,
   output logic [7:0] mem_wr_data_out,
   input wire logic [2:0] block_locked_in,
   input wire logic lock_enable_in,
   output logic lock_enable_clear_out,
   output logic block_lock_out,
   output logic recall_start_out,
   output logic copy_start_out,
   output logic [1:0] nv_block_out,
   output logic nv_copy_in_progress_out
);

   // family in the low byte, crc over the first 56 bits on top
   localparam logic [55:0] NET_LOW = {SERIAL_NUMBER, FAMILY_CODE};
   localparam logic [63:0] NET_ADDR = {swsc_crc8(NET_LOW), NET_LOW};

   typedef struct packed {
      swsc_cmd_state_t state;
      logic [5:0] bit_cnt;
      logic [1:0] phase;
      logic [7:0] shift;
      logic [7:0] func;
      logic [7:0] addr;
      logic past_end;
      logic addr_step;
      logic mismatch;
      logic wr_en;
      logic [7:0] wr_data;
      logic copy_busy;
      swsc_cnt_t copy_cnt;
      logic copy_start;
      logic recall_start;
      logic lock_start;
      logic lock_clear;
      logic [1:0] block;
      logic suspend;
   } swsc_cmd_regs_t;

   swsc_cmd_regs_t q_ff;
   swsc_cmd_regs_t nxt_q;

   logic slot_done;
   logic slot_bit;
   logic reset_seen;
   logic low_long;
   logic tx_en;
   logic tx_bit;
   logic [7:0] rx_byte;
   logic byte_end;
   logic net_bit;
   logic addr_is_ee;
   logic [1:0] addr_block;
   logic [7:0] new_is_ee_addr;
   logic new_is_ee;
   logic [1:0] new_block;

   swsc_slot_engine #(
      .RESET_CYC(RESET_CYC)
   ) u_slot (
      .ref_clk_in(ref_clk_in),
      .reset_in(reset_in),
      .dq_in(dq_in),
      .tx_en_in(tx_en),
      .tx_bit_in(tx_bit),
      .dq_oe_out(dq_oe_out),
      .slot_done_out(slot_done),
      .slot_bit_out(slot_bit),
      .reset_seen_out(reset_seen),
      .low_long_out(low_long)
   );

   // incoming bits enter at the top so the first bit ends as bit 0
   assign rx_byte = {slot_bit, q_ff.shift[7:1]};
   assign byte_end = q_ff.bit_cnt == BYTE_LAST_BIT;
   assign net_bit = NET_ADDR[q_ff.bit_cnt];
   assign addr_is_ee = q_ff.addr >= EE_FIRST && q_ff.addr <= EE_LAST;
   assign addr_block = 2'(q_ff.addr[7:BLOCK_SHIFT] - 3'h1);
   assign new_is_ee_addr = rx_byte;
   assign new_is_ee = new_is_ee_addr >= EE_FIRST && new_is_ee_addr <= EE_LAST;
   assign new_block = 2'(new_is_ee_addr[7:BLOCK_SHIFT] - 3'h1);

   // bit offered for the next slot; memory answers on the registered address
   always_comb begin
      tx_en = 1'b0;
      tx_bit = 1'b1;
      case (q_ff.state)
         CS_NET_READ: begin
            tx_en = 1'b1;
            tx_bit = net_bit;
         end
         CS_SEARCH: begin
            tx_en = q_ff.phase != 2'h2;
            tx_bit = (q_ff.phase == 2'h0) ? net_bit : !net_bit;
         end
         CS_READ: begin
            tx_en = 1'b1;
            tx_bit = q_ff.past_end || mem_rd_data_in[q_ff.bit_cnt[2:0]];
         end
         default: begin
            tx_en = 1'b0;
            tx_bit = 1'b1;
         end
      endcase
   end

   always_comb begin
      nxt_q = q_ff;
      nxt_q.wr_en = 1'b0;
      nxt_q.copy_start = 1'b0;
      nxt_q.recall_start = 1'b0;
      nxt_q.lock_start = 1'b0;
      nxt_q.lock_clear = 1'b0;
      nxt_q.addr_step = 1'b0;
      // copy timer runs on regardless of later bus resets
      if (q_ff.copy_busy) begin
         nxt_q.copy_cnt = q_ff.copy_cnt + 20'h00001;
         if (q_ff.copy_cnt == swsc_cnt_t'(COPY_CYCLES - 1)) begin
            nxt_q.copy_busy = 1'b0;
         end
      end
      nxt_q.suspend = low_long && power_saving_enable_in
                      && suspend_threshold_select_in != SUSP_THR_OFF
                      && current_in_suspend_window_in;
      // address steps one cycle after the store, so the write pulse sees its own address
      if (q_ff.addr_step) begin
         if (q_ff.addr == ADDR_LAST) begin
            nxt_q.past_end = 1'b1;
         end else begin
            nxt_q.addr = q_ff.addr + 8'h01;
         end
      end
      if (reset_seen) begin
         // partial bytes are simply dropped here
         nxt_q.state = CS_NET_CMD;
         nxt_q.bit_cnt = '0;
      end else if (slot_done) begin
         nxt_q.shift = rx_byte;
         nxt_q.bit_cnt = q_ff.bit_cnt + 6'h01;
         case (q_ff.state)
            CS_NET_CMD: begin
               if (byte_end) begin
                  nxt_q.bit_cnt = '0;
                  nxt_q.phase = 2'h0;
                  nxt_q.mismatch = 1'b0;
                  if (rx_byte == (net_address_opcode_select_in ? OP_READ_NET_B
                                                                : OP_READ_NET_A)) begin
                     nxt_q.state = CS_NET_READ;
                  end else if (rx_byte == OP_MATCH_NET) begin
                     nxt_q.state = CS_NET_MATCH;
                  end else if (rx_byte == OP_SKIP_NET) begin
                     nxt_q.state = CS_FUNC_CMD;
                  end else if (rx_byte == OP_SEARCH_NET) begin
                     nxt_q.state = CS_SEARCH;
                  end else begin
                     nxt_q.state = CS_IGNORE;
                  end
               end
            end
            CS_NET_READ: begin
               if (q_ff.bit_cnt == NET_LAST_BIT) begin
                  nxt_q.state = CS_FUNC_CMD;
                  nxt_q.bit_cnt = '0;
               end
            end
            CS_NET_MATCH: begin
               if (slot_bit != net_bit) begin
                  nxt_q.mismatch = 1'b1;
               end
               if (q_ff.bit_cnt == NET_LAST_BIT) begin
                  nxt_q.bit_cnt = '0;
                  nxt_q.state = (q_ff.mismatch || slot_bit != net_bit) ? CS_IGNORE
                                                                        : CS_FUNC_CMD;
               end
            end
            CS_SEARCH: begin
               nxt_q.bit_cnt = q_ff.bit_cnt;
               if (q_ff.phase != 2'h2) begin
                  nxt_q.phase = q_ff.phase + 2'h1;
               end else begin
                  nxt_q.phase = 2'h0;
                  nxt_q.bit_cnt = q_ff.bit_cnt + 6'h01;
                  if (slot_bit != net_bit) begin
                     nxt_q.state = CS_IGNORE;
                  end else if (q_ff.bit_cnt == NET_LAST_BIT) begin
                     nxt_q.state = CS_FUNC_CMD;
                     nxt_q.bit_cnt = '0;
                  end
               end
            end
            CS_FUNC_CMD: begin
               if (byte_end) begin
                  nxt_q.bit_cnt = '0;
                  nxt_q.func = rx_byte;
                  if (rx_byte == OP_READ_DATA || rx_byte == OP_WRITE_DATA
                      || rx_byte == OP_COPY_DATA || rx_byte == OP_RECALL_DATA
                      || rx_byte == OP_LOCK_BLOCK) begin
                     nxt_q.state = CS_ADDR;
                  end else begin
                     nxt_q.state = CS_IGNORE;
                  end
               end
            end
            CS_ADDR: begin
               if (byte_end) begin
                  nxt_q.bit_cnt = '0;
                  nxt_q.addr = rx_byte;
                  nxt_q.past_end = 1'b0;
                  nxt_q.block = new_block;
                  nxt_q.state = CS_IGNORE;
                  case (q_ff.func)
                     OP_READ_DATA: nxt_q.state = CS_READ;
                     OP_WRITE_DATA: nxt_q.state = CS_WRITE;
                     OP_COPY_DATA: begin
                        if (new_is_ee && !block_locked_in[new_block] && !q_ff.copy_busy) begin
                           nxt_q.copy_start = 1'b1;
                           nxt_q.copy_busy = 1'b1;
                           nxt_q.copy_cnt = '0;
                        end
                     end
                     OP_RECALL_DATA: begin
                        nxt_q.recall_start = new_is_ee;
                     end
                     OP_LOCK_BLOCK: begin
                        if (new_is_ee && lock_enable_in) begin
                           nxt_q.lock_start = 1'b1;
                           nxt_q.lock_clear = 1'b1;
                        end
                     end
                     default: nxt_q.state = CS_IGNORE;
                  endcase
               end
            end
            CS_READ, CS_WRITE: begin
               if (byte_end) begin
                  nxt_q.bit_cnt = '0;
                  // stores only on the eighth bit; eeprom side goes to shadow ram
                  if (q_ff.state == CS_WRITE && !q_ff.past_end && addr_writable_in
                      && !(addr_is_ee && (block_locked_in[addr_block] || q_ff.copy_busy))) begin
                     nxt_q.wr_en = 1'b1;
                     nxt_q.wr_data = rx_byte;
                  end
                  nxt_q.addr_step = 1'b1;
               end
            end
            default: begin
               nxt_q.bit_cnt = '0;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         q_ff <= '{state: CS_IDLE, default: '0};
      end else begin
         q_ff <= nxt_q;
      end
   end

   // pulldown only: the pin data is always low, the enable does the work
   assign dq_out = 1'b0;
   assign suspend_out = q_ff.suspend;
   assign mem_addr_out = q_ff.addr;
   assign mem_wr_en_out = q_ff.wr_en;
   assign mem_wr_data_out = q_ff.wr_data;
   assign lock_enable_clear_out = q_ff.lock_clear;
   assign block_lock_out = q_ff.lock_start;
   assign recall_start_out = q_ff.recall_start;
   assign copy_start_out = q_ff.copy_start;
   assign nv_block_out = q_ff.block;
   assign nv_copy_in_progress_out = q_ff.copy_busy;

endmodule

// [bench/swsc_bus_master.sv]
// bus master model: reset pulses and bit slots on the single-wire line
`timescale 1ns/1ps
module swsc_bus_master #(
   parameter int RESET_CYC = 200
) (
   input wire logic ref_clk_in,
   input wire logic dq_in,
   output logic pull_low_out
);
   int timeouts = 0;
   // line left released while idle or pausing
   initial pull_low_out = 1'b0;
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask
   // bounded wait for a line level; a bound that runs out is counted
   task automatic wait_level(input logic lvl, input int lim);
      int i;
      i = 0;
      while (dq_in !== lvl && i < lim) begin
         step(1);
         i++;
      end
      if (i >= lim) begin
         timeouts++;
      end
   endtask
   // low well past the device threshold, then watch for the answer
   task automatic bus_reset(output logic seen);
      pull_low_out = 1'b1;
      step(RESET_CYC + 50);
      pull_low_out = 1'b0;
      step(2);
      wait_level(1'b0, 2000);
      seen = (dq_in === 1'b0);
      wait_level(1'b1, 4000);
      step(20);
   endtask
   // a one releases early, a zero holds past the device's sample point
   task automatic write_bit(input logic b);
      pull_low_out = 1'b1;
      step(b ? 5 : 1520);
      pull_low_out = 1'b0;
      step(b ? 1520 : 10);
   endtask
   task automatic read_bit(output logic b);
      pull_low_out = 1'b1;
      step(3);
      pull_low_out = 1'b0;
      step(1200);
      b = dq_in;
      step(330);
      wait_level(1'b1, 500);
      step(5);
   endtask
   task automatic write_byte(input logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         write_bit(v[i]);
      end
   endtask
   task automatic read_byte(output logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         read_bit(v[i]);
      end
   endtask
endmodule

// [bench/swsc_command_layer_props.sv]
// concurrent checks on the command layer ports
`timescale 1ns/1ps
module swsc_command_layer_props import swsc_pkg::*; #(
   parameter int RESET_CYC = RESET_LOW_CYC,
   parameter int COPY_CYCLES = COPY_CYC
) (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic dq_in,
   input wire logic dq_out,
   input wire logic dq_oe_out,
   input wire logic power_saving_enable_in,
   input wire logic [1:0] suspend_threshold_select_in,
   input wire logic suspend_out,
   input wire logic [7:0] mem_addr_out,
   input wire logic addr_writable_in,
   input wire logic mem_wr_en_out,
   input wire logic [2:0] block_locked_in,
   input wire logic lock_enable_in,
   input wire logic lock_enable_clear_out,
   input wire logic block_lock_out,
   input wire logic copy_start_out,
   input wire logic [1:0] nv_block_out,
   input wire logic nv_copy_in_progress_out
);
   localparam int CP_LO = COPY_CYCLES - 3;
   typedef struct packed {
      logic [11:0] low_cnt;
      logic arm;
      logic [11:0] pres_cnt;
   } swsc_chk_t;
   swsc_chk_t st_ff;
   swsc_chk_t nxt_st;
   // only lows made by the master count, so the presence pulse never re-arms
   always_comb begin
      nxt_st = st_ff;
      nxt_st.pres_cnt = st_ff.pres_cnt + 12'h001;
      if (dq_in) begin
         nxt_st.low_cnt = 12'h000;
         if (int'(st_ff.low_cnt) > RESET_CYC) begin
            nxt_st.arm = 1'b1;
            nxt_st.pres_cnt = 12'h000;
         end
      end else if (!dq_oe_out && st_ff.low_cnt != 12'hfff) begin
         nxt_st.low_cnt = st_ff.low_cnt + 12'h001;
      end
      if (dq_oe_out) begin
         nxt_st.arm = 1'b0;
      end
   end
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);
   AST_OPEN_DRAIN: assert property (dq_out == 1'b0)
      else $error("data line driven high");
   AST_PRESENCE: assert property ($rose(dq_oe_out) && st_ff.arm
      |-> st_ff.pres_cnt inside {[12'h5d2:12'h5eb]}) else $error("presence timing off");
   AST_SLOT_ANSWER: assert property ($rose(dq_oe_out) && !st_ff.arm
      |-> !$past(dq_in) && ($past(dq_in, 2) || $past(dq_in, 3)))
      else $error("pulldown without master slot");
   AST_SUSPEND: assert property (suspend_out |-> $past(power_saving_enable_in)
      && $past(suspend_threshold_select_in) != 2'h0) else $error("suspend not allowed");
   AST_WR_WRITABLE: assert property (mem_wr_en_out |-> addr_writable_in)
      else $error("write to read-only place");
   AST_WR_LOCKED: assert property (mem_wr_en_out && mem_addr_out inside {[8'h20:8'h7f]}
      |-> !block_locked_in[mem_addr_out[6:5] - 2'h1]) else $error("write to locked block");
   AST_WR_COPY_BUSY: assert property (mem_wr_en_out && mem_addr_out inside {[8'h20:8'h7f]}
      |-> !$past(nv_copy_in_progress_out)) else $error("eeprom write during copy");
   AST_COPY_FLAG: assert property (copy_start_out |-> nv_copy_in_progress_out
      && !block_locked_in[nv_block_out] && !$past(nv_copy_in_progress_out))
      else $error("copy start wrong");
   AST_COPY_TIME: assert property ($rose(nv_copy_in_progress_out)
      |-> ##CP_LO nv_copy_in_progress_out ##[1:6] !nv_copy_in_progress_out)
      else $error("copy time wrong");
   AST_LOCK_EN: assert property (block_lock_out |-> lock_enable_in)
      else $error("lock without enable");
   AST_LOCK_CLEAR: assert property (block_lock_out |-> ##[0:1] lock_enable_clear_out)
      else $error("lock enable not cleared");
endmodule
bind swsc_command_layer swsc_command_layer_props #(
   .RESET_CYC(RESET_CYC),
   .COPY_CYCLES(COPY_CYCLES)
) swsc_command_layer_props_i (
   .ref_clk_in(ref_clk_in), .reset_in(reset_in), .dq_in(dq_in), .dq_out(dq_out),
   .dq_oe_out(dq_oe_out), .power_saving_enable_in(power_saving_enable_in),
   .suspend_threshold_select_in(suspend_threshold_select_in), .suspend_out(suspend_out),
   .mem_addr_out(mem_addr_out), .addr_writable_in(addr_writable_in),
   .mem_wr_en_out(mem_wr_en_out), .block_locked_in(block_locked_in),
   .lock_enable_in(lock_enable_in), .lock_enable_clear_out(lock_enable_clear_out),
   .block_lock_out(block_lock_out), .copy_start_out(copy_start_out),
   .nv_block_out(nv_block_out), .nv_copy_in_progress_out(nv_copy_in_progress_out)
);

// [bench/tb_top.sv]
// testbench: bus master traffic against the command layer
`timescale 1ns/1ps
module tb_top;
   import swsc_pkg::*;
   // must stay above the longest write-zero low of the master model
   localparam int RST_CYC = 2000;
   localparam logic [7:0] FAM = 8'h5a; // arbitrary value
   logic ref_clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic pullup_on = 1'b1;
   logic pse = 1'b0;
   logic win = 1'b1;
   logic [1:0] thr = 2'h0;
   logic op_sel = 1'b0;
   logic lock_en = 1'b0;
   // blocks 1 and 2 locked: a block 0 write proves the block index
   logic [2:0] locked = 3'h6;
   logic dq_o, lock_clr, blk_lock, recall_go, copy_go, copy_busy;
   logic [1:0] nv_blk;
   int nv_pulses = 0;
   logic pull_low, dq_oe, wr_en, susp, seen;
   logic [7:0] addr, wr_data, last_addr, last_data, rd_byte;
   int miscompares = 0;
   int tests_run = 0;
   int wr_cnt = 0;
   // wired-and of both pulldowns and the pullup
   wire logic dq = pullup_on & !pull_low & !dq_oe;
   swsc_command_layer #(.RESET_CYC(RST_CYC), .COPY_CYCLES(300), .FAMILY_CODE(FAM))
   swsc_command_layer_i (
      .ref_clk_in(ref_clk_in), .reset_in(reset_in), .dq_in(dq), .dq_out(dq_o), .dq_oe_out(dq_oe),
      .net_address_opcode_select_in(op_sel), .power_saving_enable_in(pse),
      .suspend_threshold_select_in(thr), .current_in_suspend_window_in(win),
      .suspend_out(susp), .mem_addr_out(addr), .mem_rd_data_in(addr ^ 8'h3c),
      .addr_writable_in(addr != 8'h00), .mem_wr_en_out(wr_en), .mem_wr_data_out(wr_data),
      .block_locked_in(locked), .lock_enable_in(lock_en), .lock_enable_clear_out(lock_clr),
      .block_lock_out(blk_lock), .recall_start_out(recall_go), .copy_start_out(copy_go),
      .nv_block_out(nv_blk), .nv_copy_in_progress_out(copy_busy)
   );
   swsc_bus_master #(.RESET_CYC(RST_CYC)) swsc_bus_master_i (
      .ref_clk_in(ref_clk_in), .dq_in(dq), .pull_low_out(pull_low)
   );
   initial begin
      forever #10 ref_clk_in = ~ref_clk_in;
   end
   always @(posedge ref_clk_in) begin
      if (wr_en === 1'b1) begin
         wr_cnt++;
         last_addr = addr;
         last_data = wr_data;
      end
      if ((lock_clr | blk_lock | recall_go | copy_go) === 1'b1) begin
         nv_pulses++;
      end
   end
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d, miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      step(8);
      reset_in = 1'b0;
      swsc_bus_master_i.bus_reset(seen);
      check({7'h00, seen}, 8'h01);
      // skip, write one whole byte into eeprom shadow, then cut the next byte short
      swsc_bus_master_i.write_byte(OP_SKIP_NET);
      swsc_bus_master_i.write_byte(OP_WRITE_DATA);
      swsc_bus_master_i.write_byte(EE_FIRST);
      swsc_bus_master_i.write_byte(8'ha5);
      check(8'(wr_cnt), 8'h01);
      check(last_addr, EE_FIRST);
      check(last_data, 8'ha5);
      check(addr, 8'h21);
      check({6'h00, nv_blk}, 8'h00);
      swsc_bus_master_i.write_bit(1'b1);
      swsc_bus_master_i.write_bit(1'b0);
      swsc_bus_master_i.write_bit(1'b1);
      swsc_bus_master_i.bus_reset(seen);
      check(8'(wr_cnt), 8'h01);
      check({7'h00, seen}, 8'h01);
      // read net address: family code comes first, lsb first
      swsc_bus_master_i.write_byte(OP_READ_NET_A);
      swsc_bus_master_i.read_byte(rd_byte);
      check(rd_byte, FAM);
      // pullup dropped: suspend only with a nonzero threshold select
      pse = 1'b1;
      pullup_on = 1'b0;
      step(RST_CYC + 30);
      check({7'h00, susp}, 8'h00);
      thr = 2'h1;
      step(10);
      check({7'h00, susp}, 8'h01);
      pullup_on = 1'b1;
      step(20);
      check(8'(nv_pulses), 8'h00);
      check({6'h00, copy_busy, dq_o}, 8'h00);
      check(8'(swsc_bus_master_i.timeouts), 8'h00);
      report_and_stop();
   end
endmodule
